// ==== rtl/tsca_pkg.sv ====
// Function
// - transmit word captured whole, bit 0 first
// - receive word bit 0 is first received
// - complementary recovered clocks at twentieth bit rate
// - wrap forces true high, complement low
// - comma enable activates sync and indicator
// - indicator marks words holding comma pattern
// - indicator lasts one word, comp-clock sampled
// - no indication while comma enable low
// - misaligned comma shifts word boundary
// - straddling or true-phase comma is misaligned
// - enable low keeps alignment indefinitely
// - wrap loops transmit stream into receiver
//
// Purpose: constants and types of the ten-bit serdes alignment block
// Assumes: one bit time per clock cycle; a word every ten cycles
// Notes:   bit positions are counted from the first bit on the line

package tsca_pkg;

   // ----------------------------------------------------------------
   // sizes and counts
   // ----------------------------------------------------------------
   localparam int unsigned CHAR_W     = 10;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [3:0]  BIT_LAST   = 4'h9;
   localparam logic [3:0]  BIT_ALIGN  = 4'h6;
   localparam logic [3:0]  BIT_REALN  = 4'h7;
   localparam logic [3:0]  BIT_MID    = 4'h4;

   // ----------------------------------------------------------------
   // patterns and reset values
   // ----------------------------------------------------------------
   localparam logic [6:0]  COMMA_PAT  = 7'h7C;
   localparam logic [9:0]  FILL_CHAR  = 10'h17C;
   localparam logic [9:0]  CHAR_RST   = 10'h000;

   typedef enum logic [1:0] {
      RX_TRUE = 2'b01,
      RX_COMP = 2'b10
   } tsca_phase_t;

   typedef struct packed {
      logic       comma;
      logic [9:0] data;
   } tsca_rx_word_t;

endpackage

// ==== rtl/tsca_top.sv ====
// Purpose: digital side of a ten-bit serdes with comma word alignment
// Assumes: serial bits move one per i_ref_clk; transmit fed through a fifo
// Notes:   recovered clocks are divided from the bit clock, not true clocks

`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// transmit word fifo
// -------------------------------------------------------------------
module tsca_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_nrst,
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic             i_wr_valid,
   output var  logic             o_wr_ready,
   output logic [WIDTH-1:0]      o_rd_data,
   output var  logic             o_rd_valid,
   input  wire logic             i_rd_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic [AW:0]      nxt_count;
   logic             push;
   logic             pop;

   assign push = i_wr_valid && o_wr_ready;
   assign pop  = o_rd_valid && i_rd_ready;
   assign o_rd_data = mem[rd_ptr_ff];

   always_comb begin
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= i_wr_data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ptr_ff  <= '0;
         rd_ptr_ff  <= '0;
         count_ff   <= '0;
         o_wr_ready <= 1'b0;
         o_rd_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         count_ff   <= nxt_count;
         o_wr_ready <= (nxt_count != (AW+1)'(DEPTH));
         o_rd_valid <= (nxt_count != '0);
      end
   end
endmodule

// -------------------------------------------------------------------
// serdes alignment top
// -------------------------------------------------------------------
module tsca_top (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_nrst,
   input  wire logic [9:0]             i_txd,
   input  wire logic                   i_txd_valid,
   output var  logic                   o_txd_ready,
   output var  logic                   o_tx_p,
   output var  logic                   o_tx_n,
   input  wire logic                   i_rx_serial,
   input  wire logic                   i_wrap_control,
   input  wire logic                   i_comma_enable,
   output var  tsca_pkg::tsca_rx_word_t o_rx_word,
   output var  logic                   o_recovered_clock,
   output var  logic                   o_recovered_clock_comp
);
   import tsca_pkg::*;

   logic [9:0]    fifo_data;
   logic          fifo_valid;
   logic          fifo_ready;
   logic [3:0]    tx_cnt_ff;
   logic [9:0]    tx_sh_ff;
   logic          rx_bit;
   logic [19:0]   rx_hist_ff;
   logic [19:0]   nxt_hist;
   logic [3:0]    rx_cnt_ff;
   logic          comma_seen;
   logic          comma_pend_ff;
   logic          rx_bound;
   logic          rclk_repeat;
   tsca_phase_t   phase_ff;
   tsca_phase_t   phase_use;
   tsca_phase_t   phase_out_ff;

   // ----------------------------------------------------------------
   // transmit path
   // ----------------------------------------------------------------
   // the fifo absorbs a partner that bursts ahead of the word slots
   tsca_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_ref_clk  (i_ref_clk),
      .i_nrst     (i_nrst),
      .i_wr_data  (i_txd),
      .i_wr_valid (i_txd_valid),
      .o_wr_ready (o_txd_ready),
      .o_rd_data  (fifo_data),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (fifo_ready)
   );

   assign fifo_ready = (tx_cnt_ff == BIT_LAST);

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_cnt_ff <= 4'h0;
      end else begin
         tx_cnt_ff <= (tx_cnt_ff == BIT_LAST) ? 4'h0 : tx_cnt_ff + 4'h1;
      end
   end

   // parallel load, lsb out
   // an empty fifo sends a comma filler so the far receiver keeps lock
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_sh_ff <= FILL_CHAR;
      end else if (tx_cnt_ff == BIT_LAST) begin
         tx_sh_ff <= fifo_valid ? fifo_data : FILL_CHAR;
      end else begin
         tx_sh_ff <= {1'b0, tx_sh_ff[9:1]};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tx_p <= 1'b1;
         o_tx_n <= 1'b0;
      end else begin
         o_tx_p <= i_wrap_control | tx_sh_ff[0];
         o_tx_n <= ~i_wrap_control & ~tx_sh_ff[0];
      end
   end

   // ----------------------------------------------------------------
   // receive path and comma search
   // ----------------------------------------------------------------
   // internal loopback
   assign rx_bit   = i_wrap_control ? tx_sh_ff[0] : i_rx_serial;
   assign nxt_hist = {rx_bit, rx_hist_ff[19:1]};
   assign rx_bound = (rx_cnt_ff == BIT_LAST);

   assign comma_seen = i_comma_enable && (nxt_hist[19:13] == COMMA_PAT);

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_hist_ff <= 20'h00000;
      end else begin
         rx_hist_ff <= nxt_hist;
      end
   end

   // move boundary three bits past comma
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_cnt_ff <= 4'h0;
      end else if (comma_seen) begin
         rx_cnt_ff <= BIT_REALN;
      end else begin
         rx_cnt_ff <= rx_bound ? 4'h0 : rx_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         comma_pend_ff <= 1'b0;
      end else if (comma_seen) begin
         comma_pend_ff <= 1'b1;
      end else if (rx_bound) begin
         comma_pend_ff <= 1'b0;
      end
   end

   // comma word goes out on the complement phase
   assign phase_use = (comma_pend_ff && rx_bound) ? RX_COMP : phase_ff;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_ff     <= RX_TRUE;
         phase_out_ff <= RX_TRUE;
      end else if (rx_bound) begin
         phase_out_ff <= phase_use;
         unique case (phase_use)
            RX_TRUE: phase_ff <= RX_COMP;
            RX_COMP: phase_ff <= RX_TRUE;
         endcase
      end
   end

   // word out, first bit in bit 0
   // indicator stands with its word only
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rx_word <= '{comma: 1'b0, data: CHAR_RST};
      end else if (rx_bound) begin
         o_rx_word.data  <= nxt_hist[19:10];
         o_rx_word.comma <= comma_pend_ff && i_comma_enable;
      end
   end

   // repeated phase drops first
   // a forced comp phase may find its clock already high; without a drop
   // the comma word would get no rising edge at all
   assign rclk_repeat = rx_bound && ((phase_use == RX_COMP) ? o_recovered_clock_comp
                                                             : o_recovered_clock);

   // clocks rise mid-word so data is settled both sides
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_recovered_clock      <= 1'b0;
         o_recovered_clock_comp <= 1'b0;
      end else if (rclk_repeat) begin
         o_recovered_clock      <= 1'b0;
         o_recovered_clock_comp <= 1'b0;
      end else if (rx_cnt_ff == BIT_MID && !comma_seen) begin
         o_recovered_clock      <= (phase_out_ff == RX_TRUE);
         o_recovered_clock_comp <= (phase_out_ff == RX_COMP);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_tx_load_word: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (tx_cnt_ff == BIT_LAST) && fifo_valid |=> tx_sh_ff == $past(fifo_data))
      else $error("transmit word not loaded at slot");

   a_tx_lsb_first: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !$past(i_wrap_control) && (tx_cnt_ff == 4'h1) |-> o_tx_p == $past(tx_sh_ff[0]))
      else $error("first line bit is not bit 0");

   a_rx_bit_order: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      rx_bound |=> o_rx_word.data == $past(nxt_hist[19:10]))
      else $error("receive word order wrong");

   a_rclk_half_rate: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_recovered_clock) && !i_comma_enable |-> !o_recovered_clock_comp ##1 o_recovered_clock[*8])
      else $error("recovered clock phase too short");

   a_wrap_line_lvl: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_wrap_control ##1 i_wrap_control |-> o_tx_p && !o_tx_n)
      else $error("wrap line state wrong");

   a_comma_pattern: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      o_rx_word.comma |-> o_rx_word.data[6:0] == COMMA_PAT)
      else $error("indicator without comma");

   a_comma_on_comp: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_rx_word.comma) |-> phase_out_ff == RX_COMP)
      else $error("comma word on true phase");

   a_comma_rclk_rise: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_rx_word.comma) |-> ##5 $rose(o_recovered_clock_comp))
      else $error("comma word without comp clock rise");

   a_comma_gated: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_rx_word.comma) |-> $past(i_comma_enable))
      else $error("indicator while disabled");

   a_realign_cnt: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      comma_seen |=> rx_cnt_ff == BIT_REALN ##3 rx_cnt_ff == 4'h0)
      else $error("boundary not placed after comma");

   a_keep_align: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !i_comma_enable && !rx_bound |=> rx_cnt_ff == $past(rx_cnt_ff) + 4'h1)
      else $error("alignment moved while disabled");

   a_loop_path: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_wrap_control |=> rx_hist_ff[19] == $past(tx_sh_ff[0]))
      else $error("loopback not taken");

   c_comma_aligned: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      comma_seen && rx_cnt_ff == BIT_ALIGN);
   c_comma_moved: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      comma_seen && rx_cnt_ff != BIT_ALIGN);
   c_fifo_full: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !o_txd_ready);
   c_wrap_comma: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_wrap_control && o_rx_word.comma);
endmodule

`default_nettype wire

// ==== test/tsca_pcs_model.sv ====
// Purpose: coding sublayer model facing the serdes alignment block
// Assumes: one line bit per i_ref_clk; words taken on recovered clock rises
// Notes:   an empty line sends toggling idle words, so it never holds a level
`timescale 1ns/1ps
`default_nettype none

module tsca_pcs_model (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_nrst,
   input  wire tsca_pkg::tsca_rx_word_t i_rx_word,
   input  wire logic                    i_rclk,
   input  wire logic                    i_rclk_comp,
   output var  logic                    o_serial
);
   import tsca_pkg::*;
   logic        bits_q[$];
   logic [11:0] cap[$];
   logic        rclk_ff;
   logic        comp_ff;

   task automatic send_word(input logic [9:0] w);
      for (int i = 0; i < 10; i++) bits_q.push_back(w[i]);
   endtask

   // -------------------------------------------------------------------
   // line source
   // -------------------------------------------------------------------
   // first bit of a word first
   always @(negedge i_ref_clk) begin
      if (bits_q.size() == 0) begin
         send_word(10'h2AA);
      end
      o_serial <= bits_q.pop_front();
   end

   // -------------------------------------------------------------------
   // word capture, entry is {comp phase, comma, data}
   // -------------------------------------------------------------------
   // sample on both rises
   always @(posedge i_ref_clk) begin
      rclk_ff <= i_rclk;
      comp_ff <= i_rclk_comp;
      if (i_nrst && i_rclk && !rclk_ff) begin
         cap.push_back({1'b0, i_rx_word});
      end
      if (i_nrst && i_rclk_comp && !comp_ff) begin
         cap.push_back({1'b1, i_rx_word});
      end
   end
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: self-checking bench of the ten-bit serdes alignment block
// Assumes: inputs change on the falling clock edge
// Notes:   receive words are judged from the partner's capture list
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import tsca_pkg::*;
   logic          i_ref_clk;
   logic          i_nrst;
   logic [9:0]    i_txd;
   logic          i_txd_valid;
   logic          o_txd_ready;
   logic          o_tx_p;
   logic          o_tx_n;
   logic          i_rx_serial;
   logic          i_wrap_control;
   logic          i_comma_enable;
   tsca_rx_word_t o_rx_word;
   logic          o_recovered_clock;
   logic          o_recovered_clock_comp;
   logic [39:0]   tx_hist;
   int            n_fail;
   int            total_checks;

   tsca_top i_tsca_top (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_txd(i_txd),
      .i_txd_valid(i_txd_valid), .o_txd_ready(o_txd_ready), .o_tx_p(o_tx_p),
      .o_tx_n(o_tx_n), .i_rx_serial(i_rx_serial), .i_wrap_control(i_wrap_control),
      .i_comma_enable(i_comma_enable), .o_rx_word(o_rx_word),
      .o_recovered_clock(o_recovered_clock), .o_recovered_clock_comp(o_recovered_clock_comp));

   tsca_pcs_model i_tsca_pcs_model (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_rx_word(o_rx_word), .i_rclk(o_recovered_clock),
      .i_rclk_comp(o_recovered_clock_comp), .o_serial(i_rx_serial));

   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) tx_hist <= {o_tx_p, tx_hist[39:1]};

   // -------------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------------
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   function automatic int n_hits(input logic [11:0] mask, input logic [11:0] val);
      n_hits = 0;
      foreach (i_tsca_pcs_model.cap[i]) if ((i_tsca_pcs_model.cap[i] & mask) === val) n_hits++;
   endfunction

   task automatic do_reset;
      i_nrst = 1'b0;
      cyc(20);
      check("line in reset", 12'({o_tx_p, o_tx_n}), 12'h002);
      check("rx in reset", 12'(o_rx_word), 12'h000);
      i_nrst = 1'b1;
      i_tsca_pcs_model.cap.delete();
   endtask

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic t_tx;
      int   acc;
      int   k;
      logic hit;
      acc = 0;
      hit = 1'b0;
      cyc(1);
      i_txd_valid = 1'b1;
      for (k = 0; k < 40 && o_txd_ready === 1'b1; k++) begin
         acc++;
         cyc(1);
      end
      i_txd_valid = 1'b0;
      check("fifo full", 12'(o_txd_ready), 12'h000);
      check("fifo taken", 12'(acc >= 16 && acc <= 18), 12'h001);
      cyc(12);
      check("fifo frees", 12'(o_txd_ready), 12'h001);
      check("tx pair", 12'(o_tx_p ^ o_tx_n), 12'h001);
      for (k = 0; k <= 30; k++) if (tx_hist[k +: 10] === 10'h0E1) hit = 1'b1;
      check("tx order", 12'(hit), 12'h001);
      cyc(170);
   endtask

   task automatic t_rx(input logic en, input int offs);
      i_comma_enable = en;
      i_tsca_pcs_model.cap.delete();
      // queue away from the partner's falling-edge pop, so the offset is exact
      @(posedge i_ref_clk);
      for (int k = 0; k < offs; k++) i_tsca_pcs_model.bits_q.push_back(k[0]);
      i_tsca_pcs_model.send_word(10'h17C);
      i_tsca_pcs_model.send_word(10'h2A5);
      cyc(80);
   endtask

   task automatic t_comma;
      t_rx(1'b1, 5);
      // straddling comma lands on comp phase
      check("comma aligned", 12'(n_hits(12'hC7F, 12'hC7C)), 12'h001);
      check("comma phase", 12'(n_hits(12'hC00, 12'h400)), 12'h000);
      check("rx order", 12'(n_hits(12'hFFF, 12'h2A5)), 12'h001);
   endtask

   task automatic t_hold;
      t_rx(1'b0, 4);
      check("no comma", 12'(n_hits(12'h400, 12'h400)), 12'h000);
      check("no realign", 12'(n_hits(12'h07F, 12'h07C)), 12'h000);
   endtask

   task automatic t_rclk;
      int hi;
      int bad;
      hi = 0;
      bad = 0;
      for (int k = 0; k < 40; k++) begin
         cyc(1);
         if (o_recovered_clock === 1'b1) hi++;
         if (o_recovered_clock === o_recovered_clock_comp) bad++;
      end
      check("rclk high", 12'(hi), 12'h014);
      check("rclk comp", 12'(bad), 12'h000);
   endtask

   task automatic t_wrap;
      i_wrap_control = 1'b1;
      i_comma_enable = 1'b1;
      for (int k = 0; k < 8; k++) begin
         cyc(10);
         check("wrap line", 12'({o_tx_p, o_tx_n}), 12'h002);
      end
      check("wrap loop", 12'(n_hits(12'hC7F, 12'hC7C) > 0), 12'h001);
      i_wrap_control = 1'b0;
   endtask

   initial begin
      n_fail = 0;
      total_checks = 0;
      i_nrst = 1'b0;
      i_txd = 10'h0E1;
      i_txd_valid = 1'b0;
      i_wrap_control = 1'b0;
      i_comma_enable = 1'b0;
      do_reset();
      t_tx();
      t_comma();
      t_hold();
      t_rclk();
      do_reset();
      t_wrap();
      close_out();
   end

   // hang guard: the full run needs about 520 cycles
   initial begin
      #(2000 * 100);
      n_fail++;
      close_out();
   end
endmodule

`default_nettype wire
